// File: verilog/pcs_top.sv
// program counter, page logic and return stack control
// assumes decoder strobes are on i_mclk and held for a whole
// instruction cycle, one strobe at a time
//
// How it works
// - counter and each stack entry are twelve bits, 4096 words.
// - pages of 1024 words; top two bits pick the page.
// - reset sets every counter bit to one.
// - direct jump loads ten low bits from the operand.
// - call loads ten low bits and pushes old count plus one.
// - all three returns pop the top entry into the whole counter.
// - accumulator move sets bits 7..0, clears bits 8 and 9.
// - accumulator add is relative to count, clears bits 8 and 9.
// - every eight-bit counter write except table lookup clears bits 8, 9.
// - table lookup adds accumulator, keeps bits 8 and 9.
// - jump, call and counter writes load page bits into 11..10.
// - cycle is two or four clocks; changing the counter adds one.
// - return stack holds five entries.
// - page select bits sit at flags bits 5 and 6; only bit 5 is writable.
// - returns leave page select bits alone.
// - upper page select bit reads zero and ignores writes.
`timescale 1ns/1ps
module pcs_top (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output      logic        o_hreadyout,
  output      logic [31:0] o_hrdata,
  output      logic        o_hresp,
  // decoder strobes
  input  wire logic        i_direct_jump_op,
  input  wire logic        i_call_op,
  input  wire logic        i_return_op,
  input  wire logic        i_return_literal_op,
  input  wire logic        i_return_irq_op,
  input  wire logic        i_table_lookup_op,
  input  wire logic        i_pc_add_op,
  input  wire logic        i_pc_mov_op,
  input  wire logic        i_pc_write_op,
  // decoder operands
  input  wire logic [pcs_pkg::PCS_OFS_W-1:0] i_operand,
  input  wire logic [pcs_pkg::PCS_ACC_W-1:0] i_acc,
  input  wire logic [pcs_pkg::PCS_ACC_W-1:0] i_pc_wdata,
  // program memory and decoder status
  output      logic [pcs_pkg::PCS_PC_W-1:0]    o_rom_addr,
  output      logic                            o_cycle_last,
  output      logic                            o_refill,
  output      logic [pcs_pkg::PCS_DEPTH_W-1:0] o_stack_depth
);
  import pcs_pkg::*;

  typedef enum logic {
    PCS_ST_EXEC   = 1'b0,
    PCS_ST_REFILL = 1'b1
  } pcs_state_t;

  typedef struct packed {
    pcs_state_t          state;
    logic [PCS_PC_W-1:0] pc;
    logic                page_low;
    logic                gp;
    logic                mode_four;
    logic [1:0]          phase;
    logic                last;
    logic                ovf;
    logic                unf;
  } pcs_top_state_t;

  localparam pcs_top_state_t PCS_TOP_RESET = '{
    state:     PCS_ST_EXEC,
    pc:        PCS_PC_RESET,
    page_low:  PCS_PAGE_RESET,
    gp:        PCS_GP_RESET,
    mode_four: PCS_MODE_RESET,
    phase:     2'h0,
    last:      1'h0,
    ovf:       1'h0,
    unf:       1'h0
  };

  pcs_top_state_t s;
  pcs_top_state_t next_s;

  pcs_stack_if stk_if ();
  pcs_reg_if   reg_if ();

  //////////////////////////////////////////////////////////////////////
  // sub blocks

  pcs_ahb u_ahb (
    .i_mclk      (i_mclk),
    .i_reset_n   (i_reset_n),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hready    (i_hready),
    .i_hwdata    (i_hwdata),
    .o_hreadyout (o_hreadyout),
    .o_hrdata    (o_hrdata),
    .o_hresp     (o_hresp),
    .regs        (reg_if.bus)
  );

  pcs_stack #(
    .N (PCS_STACK_N)
  ) u_stack (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .stk       (stk_if.stack)
  );

  //////////////////////////////////////////////////////////////////////
  // next state

  logic [PCS_PAGE_W-1:0] page;
  logic [PCS_ACC_W-1:0]  sum;
  logic [1:0]            last_phase;
  logic                  any_return;
  logic                  wr_pc;
  logic                  wr_flags;
  logic                  wr_ctrl;
  logic                  wr_stack;

  always_comb begin
    next_s = s;
    stk_if.push      = 1'h0;
    stk_if.pop       = 1'h0;
    stk_if.push_data = 12'(s.pc + 12'h001);
    // upper page bit is not built, so it is a constant zero
    page = {1'h0, s.page_low};
    sum  = 8'(s.pc[7:0] + i_acc);
    last_phase = s.mode_four ? PCS_LAST_FOUR : PCS_LAST_TWO;
    any_return = i_return_op || i_return_literal_op || i_return_irq_op;
    wr_pc    = reg_if.wr_en && (reg_if.addr == PCS_ADDR_PC);
    wr_flags = reg_if.wr_en && (reg_if.addr == PCS_ADDR_FLAGS);
    wr_ctrl  = reg_if.wr_en && (reg_if.addr == PCS_ADDR_CTRL);
    wr_stack = reg_if.wr_en && (reg_if.addr == PCS_ADDR_STACK);

    // instruction cycle phase counter
    if (s.phase == last_phase) begin
      next_s.phase = 2'h0;
    end else begin
      next_s.phase = s.phase + 2'h1;
    end

    // write one clears; an event set further down still wins
    if (wr_stack && reg_if.wdata[PCS_STK_OVF]) begin
      next_s.ovf = 1'h0;
    end
    if (wr_stack && reg_if.wdata[PCS_STK_UNF]) begin
      next_s.unf = 1'h0;
    end

    // counter update at the end of each instruction cycle
    if (s.last) begin
      unique case (s.state)
        PCS_ST_EXEC: begin
          next_s.state = PCS_ST_REFILL;
          if (any_return) begin
            // page bits are untouched, the entry picks the page
            next_s.pc  = stk_if.top_data;
            stk_if.pop = 1'h1;
            if (stk_if.depth == 3'h0) begin
              next_s.unf = 1'h1;
            end
          end else if (i_call_op) begin
            next_s.pc   = {page, i_operand};
            stk_if.push = 1'h1;
            if (stk_if.depth == PCS_DEPTH_W'(PCS_STACK_N)) begin
              next_s.ovf = 1'h1;
            end
          end else if (i_direct_jump_op) begin
            next_s.pc = {page, i_operand};
          end else if (i_table_lookup_op) begin
            next_s.pc = {page, s.pc[9:8], sum};
          end else if (i_pc_add_op) begin
            next_s.pc = {page, 2'h0, sum};
          end else if (i_pc_mov_op) begin
            next_s.pc = {page, 2'h0, i_acc};
          end else if (i_pc_write_op) begin
            next_s.pc = {page, 2'h0, i_pc_wdata};
          end else begin
            // plain step wraps from the top address to zero
            next_s.pc    = 12'(s.pc + 12'h001);
            next_s.state = PCS_ST_EXEC;
          end
        end
        PCS_ST_REFILL: begin
          // the extra cycle only fetches the new target
          next_s.state = PCS_ST_EXEC;
        end
      endcase
    end

    // software access, which wins over the decoder in the same cycle
    if (wr_pc) begin
      next_s.pc    = {page, 2'h0, reg_if.wdata[7:0]};
      next_s.state = PCS_ST_REFILL;
      next_s.phase = 2'h0;
    end
    if (wr_flags) begin
      next_s.page_low = reg_if.wdata[PCS_FLAG_PAGE_LO];
      next_s.gp       = reg_if.wdata[PCS_FLAG_GP];
    end
    if (wr_ctrl) begin
      next_s.mode_four = reg_if.wdata[PCS_CTRL_FOUR];
      next_s.phase     = 2'h0;
    end
    next_s.last = (next_s.phase ==
                   (next_s.mode_four ? PCS_LAST_FOUR : PCS_LAST_TWO));

    // read mux, unmapped offsets read zero
    reg_if.rdata = 32'h0000_0000;
    if (reg_if.rd_en) begin
      unique case (reg_if.addr)
        PCS_ADDR_PC: begin
          reg_if.rdata[PCS_PC_W-1:0] = s.pc;
        end
        PCS_ADDR_FLAGS: begin
          reg_if.rdata[PCS_FLAG_PAGE_LO] = s.page_low;
          reg_if.rdata[PCS_FLAG_PAGE_HI] = 1'h0;
          reg_if.rdata[PCS_FLAG_GP]      = s.gp;
        end
        PCS_ADDR_CTRL: begin
          reg_if.rdata[PCS_CTRL_FOUR] = s.mode_four;
        end
        PCS_ADDR_STACK: begin
          reg_if.rdata[PCS_DEPTH_W-1:0] = stk_if.depth;
          reg_if.rdata[PCS_STK_OVF]     = s.ovf;
          reg_if.rdata[PCS_STK_UNF]     = s.unf;
        end
        PCS_ADDR_TOP: begin
          reg_if.rdata[PCS_PC_W-1:0] = stk_if.top_data;
        end
        default: begin
          reg_if.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= PCS_TOP_RESET;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign o_rom_addr    = s.pc;
  assign o_cycle_last  = s.last;
  assign o_refill      = s.state;
  assign o_stack_depth = stk_if.depth;
endmodule

// File: common/pcs_pkg.sv
// constants of the program counter and return stack block
// assumes the decoder and bus run on the one core clock
package pcs_pkg;
  // widths and sizes
  localparam int PCS_PC_W     = 12;
  localparam int PCS_OFS_W    = 10;
  localparam int PCS_ACC_W    = 8;
  localparam int PCS_PAGE_W   = 2;
  localparam int PCS_STACK_N  = 5;
  localparam int PCS_DEPTH_W  = 3;
  localparam int PCS_ADDR_W   = 8;
  localparam int PCS_PAGE_WORDS = 1024;

  // reset values
  localparam logic [11:0] PCS_PC_RESET   = 12'hFFF;
  localparam logic        PCS_PAGE_RESET = 1'h0;
  localparam logic        PCS_GP_RESET   = 1'h0;
  localparam logic        PCS_MODE_RESET = 1'h0;

  // register byte offsets
  localparam logic [7:0] PCS_ADDR_PC    = 8'h00;
  localparam logic [7:0] PCS_ADDR_FLAGS = 8'h04;
  localparam logic [7:0] PCS_ADDR_CTRL  = 8'h08;
  localparam logic [7:0] PCS_ADDR_STACK = 8'h0C;
  localparam logic [7:0] PCS_ADDR_TOP   = 8'h10;

  // field positions
  localparam int PCS_FLAG_PAGE_LO = 5;
  localparam int PCS_FLAG_PAGE_HI = 6;
  localparam int PCS_FLAG_GP      = 7;
  localparam int PCS_CTRL_FOUR    = 0;
  localparam int PCS_STK_OVF      = 8;
  localparam int PCS_STK_UNF      = 9;

  // oscillator clocks per instruction cycle
  localparam int PCS_CLKS_TWO  = 2;
  localparam int PCS_CLKS_FOUR = 4;
  localparam logic [1:0] PCS_LAST_TWO  = 2'(PCS_CLKS_TWO - 1);
  localparam logic [1:0] PCS_LAST_FOUR = 2'(PCS_CLKS_FOUR - 1);

  // bus encodings
  localparam logic [1:0] PCS_HTRANS_IDLE = 2'h0;
endpackage

// File: common/pcs_stack_if.sv
// link between the counter logic and the return stack
// assumes push and pop are never raised together
`timescale 1ns/1ps
interface pcs_stack_if;
  import pcs_pkg::*;
  logic                   push;
  logic                   pop;
  logic [PCS_PC_W-1:0]    push_data;
  logic [PCS_PC_W-1:0]    top_data;
  logic [PCS_DEPTH_W-1:0] depth;
  modport ctrl  (output push, pop, push_data, input top_data, depth);
  modport stack (input push, pop, push_data, output top_data, depth);
endinterface

// File: common/pcs_reg_if.sv
// register access strobes from the bus front end
// assumes the register side answers rdata in the same cycle
`timescale 1ns/1ps
interface pcs_reg_if;
  import pcs_pkg::*;
  logic                  wr_en;
  logic                  rd_en;
  logic [PCS_ADDR_W-1:0] addr;
  logic [31:0]           wdata;
  logic [31:0]           rdata;
  modport bus  (output wr_en, rd_en, addr, wdata, input rdata);
  modport regs (input wr_en, rd_en, addr, wdata, output rdata);
endinterface

// File: verilog/pcs_stack.sv
// five-entry return address stack, entry 0 is the top
// assumes push and pop are exclusive in any cycle
`timescale 1ns/1ps
module pcs_stack #(
  parameter int N = pcs_pkg::PCS_STACK_N
) (
  // clock and reset
  input  wire logic  i_mclk,
  input  wire logic  i_reset_n,
  // counter side
  pcs_stack_if.stack stk
);
  import pcs_pkg::*;

  typedef struct packed {
    logic [N-1:0][PCS_PC_W-1:0] entry;
    logic [PCS_DEPTH_W-1:0]     depth;
  } pcs_stack_state_t;

  pcs_stack_state_t s;
  pcs_stack_state_t next_s;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    if (stk.push) begin
      // shifting drops the oldest entry when full
      for (int i = N - 1; i > 0; i--) begin
        next_s.entry[i] = s.entry[i-1];
      end
      next_s.entry[0] = stk.push_data;
      if (s.depth != PCS_DEPTH_W'(N)) begin
        next_s.depth = s.depth + 3'h1;
      end
    end else if (stk.pop) begin
      for (int i = 0; i < N - 1; i++) begin
        next_s.entry[i] = s.entry[i+1];
      end
      // zero fill keeps an empty pop deterministic
      next_s.entry[N-1] = '0;
      if (s.depth != 3'h0) begin
        next_s.depth = s.depth - 3'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign stk.top_data = s.entry[0];
  assign stk.depth    = s.depth;
endmodule

// File: verilog/pcs_ahb.sv
// AHB-Lite slave front end, zero wait writes, one wait reads
// assumes single word transfers and one slave on the bus
`timescale 1ns/1ps
module pcs_ahb (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output      logic        o_hreadyout,
  output      logic [31:0] o_hrdata,
  output      logic        o_hresp,
  // register side
  pcs_reg_if.bus           regs
);
  import pcs_pkg::*;

  typedef struct packed {
    logic                  wr_pend;
    logic                  rd_pend;
    logic [PCS_ADDR_W-1:0] addr;
    logic                  readyout;
    logic [31:0]           rdata;
  } pcs_ahb_state_t;

  pcs_ahb_state_t s;
  pcs_ahb_state_t next_s;
  logic           accept;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s         = s;
    next_s.wr_pend = 1'h0;
    next_s.rd_pend = 1'h0;
    accept = i_hsel && i_hready && (i_htrans[1] != PCS_HTRANS_IDLE[1]);
    // read data is taken one cycle late so a write just ahead lands
    if (s.rd_pend) begin
      next_s.rdata    = regs.rdata;
      next_s.readyout = 1'h1;
    end
    if (accept) begin
      next_s.addr = i_haddr[PCS_ADDR_W-1:0];
      if (i_hwrite) begin
        next_s.wr_pend = 1'h1;
      end else begin
        next_s.rd_pend  = 1'h1;
        next_s.readyout = 1'h0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '{wr_pend: 1'h0, rd_pend: 1'h0, addr: '0,
             readyout: 1'h1, rdata: '0};
    end else begin
      s <= next_s;
    end
  end

  assign regs.wr_en = s.wr_pend;
  assign regs.rd_en = s.rd_pend;
  assign regs.addr  = s.addr;
  assign regs.wdata = i_hwdata;
  assign o_hreadyout = s.readyout;
  assign o_hrdata    = s.rdata;
  // the response is always OKAY
  assign o_hresp     = 1'h0;
endmodule

// File: testbench/pcs_checker.sv
// port assertions for the program counter block
// assumes one clock domain; bound into every pcs_top
`timescale 1ns/1ps
module pcs_checker (
  // clock, reset and bus
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  // decoder strobes and operands
  input wire logic        i_direct_jump_op,
  input wire logic        i_call_op,
  input wire logic        i_return_op,
  input wire logic        i_return_literal_op,
  input wire logic        i_return_irq_op,
  input wire logic        i_table_lookup_op,
  input wire logic        i_pc_add_op,
  input wire logic        i_pc_mov_op,
  input wire logic        i_pc_write_op,
  input wire logic [9:0]  i_operand,
  input wire logic [7:0]  i_acc,
  // counter status
  input wire logic [11:0] o_rom_addr,
  input wire logic        o_cycle_last,
  input wire logic        o_refill,
  input wire logic [2:0]  o_stack_depth
);
  import pcs_pkg::*;
  logic       wr_pend;
  logic [2:0] rcnt;
  wire rets = i_return_op | i_return_literal_op | i_return_irq_op;
  wire hi   = rets | i_call_op | i_direct_jump_op;
  wire low  = i_table_lookup_op | i_pc_add_op | i_pc_mov_op | i_pc_write_op;
  // a bus write landing on the same edge beats the decoder
  wire go   = o_cycle_last & ~o_refill & ~wr_pend;
  ////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend <= 1'b0;
      rcnt    <= 3'h0;
    end else begin
      wr_pend <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
      rcnt    <= o_refill ? rcnt + 3'h1 : 3'h0;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence s_refill_start;
    o_refill && !o_cycle_last;
  endsequence
  chk_reset_top: assert property ($rose(i_reset_n) |->
    o_rom_addr == PCS_PC_RESET) else $error("counter not all ones");
  chk_jump_low: assert property (go && i_direct_jump_op && !rets
    && !i_call_op |=> o_rom_addr[9:0] == $past(i_operand)
    && !o_rom_addr[11]) else $error("jump target wrong");
  chk_call_push: assert property (go && i_call_op && !rets |=>
    o_stack_depth == ($past(o_stack_depth) == 3'h5 ? 3'h5
    : $past(o_stack_depth) + 3'h1)) else $error("call depth wrong");
  chk_ret_pop: assert property (go && rets |=> o_stack_depth ==
    ($past(o_stack_depth) == 3'h0 ? 3'h0 : $past(o_stack_depth) - 3'h1))
    else $error("return depth wrong");
  chk_table_keep: assert property (go && i_table_lookup_op && !hi |=>
    o_rom_addr[9:0] == {$past(o_rom_addr[9:8]),
    8'($past(o_rom_addr[7:0]) + $past(i_acc))}) else $error("table wrong");
  chk_mov_clear: assert property (go && i_pc_mov_op && !hi
    && !i_table_lookup_op && !i_pc_add_op |=>
    o_rom_addr[9:0] == {2'h0, $past(i_acc)}) else $error("move wrong");
  chk_step_one: assert property (go && !hi && !low |=>
    o_rom_addr == $past(o_rom_addr) + 12'h1) else $error("no step");
  chk_flow_refill: assert property (go && (hi || low) |=>
    s_refill_start) else $error("no refill cycle");
  chk_refill_hold: assert property (o_refill && !wr_pend |=>
    $stable(o_rom_addr)) else $error("counter moved in refill");
  chk_refill_len: assert property ($fell(o_refill) |->
    rcnt == 3'h2 || rcnt == 3'h4) else $error("refill length wrong");
  chk_cycle_gap: assert property (o_cycle_last |=>
    !o_cycle_last) else $error("cycle shorter than two clocks");
endmodule

bind pcs_top pcs_checker u_pcs_checker (
  .i_mclk, .i_reset_n, .i_hsel, .i_htrans, .i_hwrite, .i_hready,
  .i_direct_jump_op, .i_call_op, .i_return_op, .i_return_literal_op,
  .i_return_irq_op, .i_table_lookup_op, .i_pc_add_op, .i_pc_mov_op,
  .i_pc_write_op, .i_operand, .i_acc, .o_rom_addr, .o_cycle_last,
  .o_refill, .o_stack_depth
);

// File: testbench/pcs_dec_model.sv
// instruction decoder model: one strobe per instruction cycle
// assumes the block flags cycle ends and refill cycles
`timescale 1ns/1ps
module pcs_dec_model (
  // clock
  input  wire logic        i_mclk,
  // counter status
  input  wire logic        i_cycle_last,
  input  wire logic        i_refill,
  input  wire logic [11:0] i_rom_addr,
  // strobes and operands
  output      logic [8:0]  o_ops,
  output      logic [9:0]  o_operand,
  output      logic [7:0]  o_acc,
  output      logic [7:0]  o_wdata
);
  initial begin
    o_ops     = 9'h000;
    o_operand = 10'h000;
    o_acc     = 8'h00;
    o_wdata   = 8'h00;
  end
  // held over whole cycles, refill ones too; only the last edge counts
  task automatic issue(input int k, input logic [9:0] opd,
                       input logic [7:0] v, output logic [11:0] at);
    int n;
    n = 0;
    do begin @(negedge i_mclk); n++; end
    while (i_cycle_last !== 1'b1 && n < 50);
    @(posedge i_mclk);
    o_ops     <= 9'h001 << k;
    o_operand <= opd;
    o_acc     <= v;
    o_wdata   <= ~v;
    n = 0;
    do begin @(negedge i_mclk); n++; end
    while (!(i_cycle_last === 1'b1 && i_refill === 1'b0) && n < 50);
    at = i_rom_addr;
    @(posedge i_mclk);
    // released operands must not keep their last value
    o_ops     <= 9'h000;
    o_operand <= ~opd;
    o_acc     <= ~v;
    o_wdata   <= v;
    n = 0;
    do begin @(negedge i_mclk); n++; end
    while (i_refill !== 1'b0 && n < 50);
  endtask
endmodule

// File: testbench/testbench.sv
// self-checking bench for the program counter block
// assumes the decoder model drives strobes and the checker is bound
`timescale 1ns/1ps
module testbench;
  import pcs_pkg::*;
  logic        mclk    = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = PCS_HTRANS_IDLE;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [8:0]  ops;
  logic [9:0]  opd;
  logic [7:0]  acc;
  logic [7:0]  wdat;
  logic [11:0] pc;
  logic        cl;
  logic        refill;
  logic [2:0]  depth;
  logic [31:0] rd;
  logic [11:0] at;
  logic        pl      = 1'b0;
  logic [11:0] pushed [$];
  int          miscompares = 0;
  int          num_checks  = 0;
  always #2 mclk = ~mclk;
  pcs_top u_pcs_top (
    .i_mclk(mclk), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hready(hready),
    .i_hwdata(hwdata), .o_hreadyout(hready), .o_hrdata(hrdata),
    .o_hresp(hresp), .i_direct_jump_op(ops[0]), .i_call_op(ops[1]),
    .i_return_op(ops[2]), .i_return_literal_op(ops[3]),
    .i_return_irq_op(ops[4]), .i_table_lookup_op(ops[5]),
    .i_pc_add_op(ops[6]), .i_pc_mov_op(ops[7]), .i_pc_write_op(ops[8]),
    .i_operand(opd), .i_acc(acc), .i_pc_wdata(wdat), .o_rom_addr(pc),
    .o_cycle_last(cl), .o_refill(refill), .o_stack_depth(depth)
  );
  pcs_dec_model u_pcs_dec_model (
    .i_mclk(mclk), .i_cycle_last(cl), .i_refill(refill),
    .i_rom_addr(pc), .o_ops(ops), .o_operand(opd), .o_acc(acc),
    .o_wdata(wdat)
  );
  ////////////////////////////////////////
  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // single word transfer; the master waits on hready for wait states
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    int n;
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 20);
    htrans <= PCS_HTRANS_IDLE;
    hwdata <= wd;
    n = 0;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 20);
    q = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic op(input int k, input logic [9:0] o, input logic [7:0] v);
    logic [11:0] e;
    u_pcs_dec_model.issue(k, o, v, at);
    case (k)
      0, 1:    e = {1'b0, pl, o};
      2, 3, 4: e = (pushed.size() > 0) ? pushed.pop_back() : 12'h000;
      5:       e = {1'b0, pl, at[9:8], at[7:0] + v};
      6:       e = {1'b0, pl, 2'h0, at[7:0] + v};
      7:       e = {1'b0, pl, 2'h0, v};
      default: e = {1'b0, pl, 2'h0, ~v};
    endcase
    if (k == 1) begin
      if (pushed.size() == 5) pushed.delete(0);
      pushed.push_back(at + 12'h1);
    end
    check("rom_addr", 32'(e), 32'(pc));
  endtask
  task automatic t_gap(input logic [31:0] n);
    logic [31:0] c;
    c = 32'h0;
    do begin @(negedge mclk); c++; end while (cl !== 1'b1 && c < 32'h40);
    c = 32'h0;
    do begin @(negedge mclk); c++; end while (cl !== 1'b1 && c < 32'h40);
    check("cycle_clocks", n, c);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    check("rom_addr", 32'hFFF, 32'(pc));
    check("depth", 32'h0, 32'(depth));
    reset_n <= 1'b1;
    t_gap(32'h2);
    check("rom_addr", 32'h000, 32'(pc));
    @(posedge mclk);
    #1;
    check("rom_addr", 32'h001, 32'(pc));
  endtask
  task automatic t_rerun();
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    check("rom_addr", 32'hFFF, 32'(pc));
    reset_n <= 1'b1;
    t_gap(32'h2);
    check("rom_addr", 32'h000, 32'(pc));
  endtask
  task automatic t_regs();
    bus(1'b1, PCS_ADDR_FLAGS, 32'hFF, rd);
    bus(1'b0, PCS_ADDR_FLAGS, 32'h0, rd);
    check("flags", 32'hA0, rd);
    check("hresp", 32'h0, 32'(hresp));
    bus(1'b0, 8'h14, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    bus(1'b1, PCS_ADDR_FLAGS, 32'h20, rd);
    pl = 1'b1;
  endtask
  task automatic t_ops();
    op(0, 10'h3FF, 8'h00);
    op(5, 10'h000, 8'h05);
    op(6, 10'h000, 8'h10);
    op(7, 10'h000, 8'hAB);
    op(8, 10'h000, 8'hC3);
  endtask
  task automatic t_stack();
    for (int i = 0; i < 6; i++) op(1, 10'(i * 64 + 1), 8'h00);
    check("depth", 32'h5, 32'(depth));
    bus(1'b0, PCS_ADDR_STACK, 32'h0, rd);
    check("stack_status", 32'h105, rd);
    bus(1'b0, PCS_ADDR_TOP, 32'h0, rd);
    check("stack_top", 32'(pushed[pushed.size() - 1]), rd);
    bus(1'b1, PCS_ADDR_FLAGS, 32'h0, rd);
    pl = 1'b0;
    for (int i = 0; i < 6; i++) op(2 + i % 3, 10'h0, 8'h00);
    check("depth", 32'h0, 32'(depth));
    bus(1'b0, PCS_ADDR_STACK, 32'h0, rd);
    check("stack_status", 32'h300, rd);
    bus(1'b1, PCS_ADDR_STACK, 32'h300, rd);
    bus(1'b0, PCS_ADDR_STACK, 32'h0, rd);
    check("stack_status", 32'h0, rd);
  endtask
  task automatic t_four();
    bus(1'b1, PCS_ADDR_CTRL, 32'h1, rd);
    t_gap(32'h4);
    op(0, 10'h155, 8'h00);
    bus(1'b1, PCS_ADDR_CTRL, 32'h0, rd);
    t_gap(32'h2);
  endtask
  task automatic t_bus_pc();
    bus(1'b1, PCS_ADDR_FLAGS, 32'h20, rd);
    pl = 1'b1;
    bus(1'b1, PCS_ADDR_PC, 32'h3A5, rd);
    #1;
    check("rom_addr", 32'h4A5, 32'(pc));
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    t_reset();
    t_regs();
    t_ops();
    t_stack();
    t_four();
    t_bus_pc();
    t_rerun();
    give_verdict();
  end
  // whole run is a few hundred clocks
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule
